// ==== rtl/tcp_consts.svh ====
// constants of the timer compare, pwm and slave control block
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define TCP_OFS_CTRL 8'h00
`define TCP_OFS_SLAVE 8'h08
`define TCP_OFS_IRQEN 8'h0C
`define TCP_OFS_STATUS 8'h10
`define TCP_OFS_EVGEN 8'h14
`define TCP_OFS_CHMODE 8'h18
`define TCP_OFS_CHOUT 8'h20
`define TCP_OFS_CNT 8'h24
`define TCP_OFS_ARR 8'h2C
`define TCP_OFS_CCR1 8'h34
`define TCP_OFS_CCR2 8'h38

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define TCP_CTRL_RUN 0
`define TCP_CTRL_URS 2
`define TCP_CTRL_SP 3
`define TCP_CTRL_AUTORELOAD_PRELOAD_ENABLE 7
`define TCP_SLV_SMS 0
`define TCP_SLV_TS 4
`define TCP_FLG_UPD 0
`define TCP_FLG_CC 1
`define TCP_FLG_TRG 6
`define TCP_EVG_UG 0
`define TCP_CHM_STRIDE 8
`define TCP_CHM_FE 2
`define TCP_CHM_PE 3
`define TCP_CHM_MODE 4
`define TCP_CHO_STRIDE 4
`define TCP_CHO_EN 0
`define TCP_CHO_POL 1
`define TCP_CHO_NPOL 3

// -----------------------------------------------------------------
// codes and reset values
// -----------------------------------------------------------------
`define TCP_MODE_FROZEN 3'h0
`define TCP_MODE_ACTIVE 3'h1
`define TCP_MODE_INACT 3'h2
`define TCP_MODE_TOGGLE 3'h3
`define TCP_MODE_FORCE_LO 3'h4
`define TCP_MODE_FORCE_HI 3'h5
`define TCP_MODE_PWM1 3'h6
`define TCP_MODE_PWM2 3'h7
`define TCP_SMS_RESET 3'h4
`define TCP_SMS_GATED 3'h5
`define TCP_SMS_TRIGGER 3'h6
`define TCP_TS_IN1 3'h5
`define TCP_TS_IN2 3'h6
`define TCP_ARR_RST 16'hFFFF
`define TCP_ZERO16 16'h0000
`define TCP_ONE16 16'h0001
`define TCP_OE_OFF 2'h3

`endif

// ==== rtl/tcp_pkg.sv ====
// types of the timer compare, pwm and slave control block
package tcp_pkg;

    typedef logic [2:0] tcp_mode_t;

    typedef struct packed {
        logic ref_lvl;
        logic forced;
    } tcp_chan_s;

    typedef struct packed {
        logic run;
        logic update_source_select;
        logic sp;
        logic autoreload_preload_enable;
        logic [2:0] slave_mode_field;
        logic [2:0] ts;
        logic [1:0] cc_ie;
        logic trg_ie;
        logic upd_f;
        logic [1:0] cc_f;
        logic trg_f;
        logic [15:0] chmode;
        logic [7:0] chout;
        logic [15:0] cnt;
        logic [15:0] arr_pre;
        logic [15:0] arr_act;
        logic [1:0][15:0] ccr_pre;
        logic [1:0][15:0] ccr_act;
        logic [15:0] rdata;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic trg_prev;
        logic cnt_new;
        logic fast_kick;
        logic [1:0] out_lvl;
        logic [1:0] out_oe_b;
        logic irq;
    } tcp_top_s;

endpackage

// ==== rtl/tcp_chan_if.sv ====
// link between the timer core and one channel output stage
`timescale 1ns/100ps
interface tcp_chan_if;
    logic [15:0] cnt;
    logic [15:0] cmp;
    logic cnt_new;
    tcp_pkg::tcp_mode_t mode;
    logic fast_en;
    logic fast_kick;
    logic ref_lvl;
    logic match;

    modport ctl (output cnt, cmp, cnt_new, mode, fast_en, fast_kick, input ref_lvl, match);
    modport chan (input cnt, cmp, cnt_new, mode, fast_en, fast_kick, output ref_lvl, match);
endinterface

// ==== rtl/tcp_chan.sv ====
// one channel output stage: compare actions and pwm reference
`timescale 1ns/100ps
`include "tcp_consts.svh"
module tcp_chan (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // core side
    tcp_chan_if.chan ch
);
    tcp_pkg::tcp_chan_s s_reg;
    tcp_pkg::tcp_chan_s s_next;
    logic below;
    logic pwm;

    assign below = ch.cnt < ch.cmp;
    assign pwm = (ch.mode == `TCP_MODE_PWM1) || (ch.mode == `TCP_MODE_PWM2);
    assign ch.match = ch.cnt_new && (ch.cnt == ch.cmp);
    assign ch.ref_lvl = s_reg.ref_lvl;

    // -------------------------------------------------------------
    // reference waveform
    // -------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        unique case (ch.mode)
            `TCP_MODE_FROZEN: s_next.ref_lvl = s_reg.ref_lvl;
            `TCP_MODE_ACTIVE: if (ch.match) s_next.ref_lvl = 1'h1;
            `TCP_MODE_INACT: if (ch.match) s_next.ref_lvl = 1'h0;
            `TCP_MODE_TOGGLE: if (ch.match) s_next.ref_lvl = ~s_reg.ref_lvl;
            `TCP_MODE_FORCE_LO: s_next.ref_lvl = 1'h0;
            `TCP_MODE_FORCE_HI: s_next.ref_lvl = 1'h1;
            `TCP_MODE_PWM1: s_next.ref_lvl = below;
            `TCP_MODE_PWM2: s_next.ref_lvl = ~below;
        endcase
        // fast path holds the matched level until the real match
        if (pwm && ch.fast_en && ch.fast_kick) begin
            s_next.forced = 1'h1;
        end else if (ch.match || !pwm) begin
            s_next.forced = 1'h0;
        end
        if (s_next.forced) begin
            s_next.ref_lvl = (ch.mode == `TCP_MODE_PWM2);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_frozen_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        ch.mode == `TCP_MODE_FROZEN |=> $stable(s_reg.ref_lvl))
        else $error("frozen mode changed the reference");
    a_toggle_match: assert property (@(posedge mclk) disable iff (!rst_b)
        ch.mode == `TCP_MODE_TOGGLE && ch.match |=> s_reg.ref_lvl != $past(s_reg.ref_lvl))
        else $error("toggle on match missed");
    a_pwm1_level: assert property (@(posedge mclk) disable iff (!rst_b)
        ch.mode == `TCP_MODE_PWM1 && !s_next.forced |=> s_reg.ref_lvl == $past(below))
        else $error("pwm1 reference wrong");
    a_fast_force: assert property (@(posedge mclk) disable iff (!rst_b)
        pwm && ch.fast_en && ch.fast_kick |=> s_reg.forced
            && s_reg.ref_lvl == ($past(ch.mode) == `TCP_MODE_PWM2))
        else $error("fast enable did not force the reference");
endmodule // tcp_chan

// ==== rtl/tcp_top.sv ====
// timer core: counter, slave control, registers and channel outputs
//
// Notes on behaviour
// - match drives output per compare mode
// - every match sets channel match flag
// - match irq only when enabled
// - preload off writes now, else at update
// - update leaves compare-mode reference untouched
// - modes 110/111 give pwm per channel
// - pwm1 high while counter below compare
// - pwm1 full high or full low extremes
// - polarity bit and output enable bit
// - up-counting only, edge-aligned pwm
// - single pulse stops counter at update
// - delay is compare, length is reload minus compare plus one
// - trigger edge sets run bit
// - fast enable forces matched level on trigger
// - reset mode restarts counter, maybe updates
// - reset trigger: zero, flag, irq if enabled
// - gated mode counts while level active
// - gated mode flags start and stop
// - select routes input one or two
// - trigger mode edge starts counter
// - single pulse update clears run bit
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "tcp_consts.svh"
module tcp_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // trigger pins
    input wire logic [1:0] trig_in,
    // waveform pins and request
    output logic [1:0] chan_out,
    output logic [1:0] chan_oe_b,
    output logic irq_req
);
    tcp_pkg::tcp_top_s s_reg;
    tcp_pkg::tcp_top_s s_next;
    logic [1:0] inv;
    logic [1:0] ref_lvl;
    logic [1:0] match;
    logic lvl;
    logic edge_det;
    logic gate_ok;
    logic adv;
    logic ovf;
    logic ug;
    logic rst_trig;
    logic upd;
    logic cnt_wr;

    // -------------------------------------------------------------
    // trigger path
    // -------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_inv
            assign inv[gi] = s_reg.chout[gi * `TCP_CHO_STRIDE + `TCP_CHO_POL]
                && !s_reg.chout[gi * `TCP_CHO_STRIDE + `TCP_CHO_NPOL];
        end
    endgenerate

    always_comb begin
        unique case (s_reg.ts)
            `TCP_TS_IN1: lvl = s_reg.sync2[0] ^ inv[0];
            `TCP_TS_IN2: lvl = s_reg.sync2[1] ^ inv[1];
            default: lvl = 1'h0;
        endcase
    end

    assign edge_det = lvl && !s_reg.trg_prev;
    assign gate_ok = (s_reg.slave_mode_field != `TCP_SMS_GATED) || lvl;
    assign adv = s_reg.run && gate_ok;
    assign ovf = adv && (s_reg.cnt == s_reg.arr_act);
    assign ug = reg_wr && (reg_addr == `TCP_OFS_EVGEN) && reg_wdata[`TCP_EVG_UG];
    assign rst_trig = (s_reg.slave_mode_field == `TCP_SMS_RESET) && edge_det;
    assign upd = ovf || ug || (rst_trig && !s_reg.update_source_select);
    assign cnt_wr = reg_wr && (reg_addr == `TCP_OFS_CNT);

    // -------------------------------------------------------------
    // channels
    // -------------------------------------------------------------
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            tcp_chan_if ch_if ();
            assign ch_if.cnt = s_reg.cnt;
            assign ch_if.cmp = s_reg.ccr_act[gi];
            assign ch_if.cnt_new = s_reg.cnt_new;
            assign ch_if.mode = s_reg.chmode[gi * `TCP_CHM_STRIDE + `TCP_CHM_MODE +: 3];
            assign ch_if.fast_en = s_reg.chmode[gi * `TCP_CHM_STRIDE + `TCP_CHM_FE];
            assign ch_if.fast_kick = s_reg.fast_kick;
            assign ref_lvl[gi] = ch_if.ref_lvl;
            assign match[gi] = ch_if.match;
            tcp_chan u_chan (
                .mclk(mclk),
                .rst_b(rst_b),
                .ch(ch_if.chan)
            );
        end
    endgenerate

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = trig_in;
        s_next.sync2 = s_reg.sync1;
        s_next.trg_prev = lvl;
        s_next.fast_kick = edge_det;

        // software writes
        if (reg_wr) begin
            unique case (reg_addr)
                `TCP_OFS_CTRL: begin
                    s_next.run = reg_wdata[`TCP_CTRL_RUN];
                    s_next.update_source_select = reg_wdata[`TCP_CTRL_URS];
                    s_next.sp = reg_wdata[`TCP_CTRL_SP];
                    s_next.autoreload_preload_enable = reg_wdata[`TCP_CTRL_AUTORELOAD_PRELOAD_ENABLE];
                end
                `TCP_OFS_SLAVE: begin
                    s_next.slave_mode_field = reg_wdata[`TCP_SLV_SMS +: 3];
                    s_next.ts = reg_wdata[`TCP_SLV_TS +: 3];
                end
                `TCP_OFS_IRQEN: begin
                    s_next.cc_ie = reg_wdata[`TCP_FLG_CC +: 2];
                    s_next.trg_ie = reg_wdata[`TCP_FLG_TRG];
                end
                `TCP_OFS_STATUS: begin
                    // writing zero clears, set below still wins
                    s_next.upd_f = s_reg.upd_f && reg_wdata[`TCP_FLG_UPD];
                    s_next.cc_f = s_reg.cc_f & reg_wdata[`TCP_FLG_CC +: 2];
                    s_next.trg_f = s_reg.trg_f && reg_wdata[`TCP_FLG_TRG];
                end
                `TCP_OFS_CHMODE: s_next.chmode = reg_wdata;
                `TCP_OFS_CHOUT: s_next.chout = reg_wdata[7:0];
                `TCP_OFS_CNT: s_next.cnt = reg_wdata;
                `TCP_OFS_ARR: begin
                    s_next.arr_pre = reg_wdata;
                    if (!s_reg.autoreload_preload_enable) s_next.arr_act = reg_wdata;
                end
                `TCP_OFS_CCR1: begin
                    s_next.ccr_pre[0] = reg_wdata;
                    if (!s_reg.chmode[`TCP_CHM_PE]) s_next.ccr_act[0] = reg_wdata;
                end
                `TCP_OFS_CCR2: begin
                    s_next.ccr_pre[1] = reg_wdata;
                    if (!s_reg.chmode[`TCP_CHM_STRIDE + `TCP_CHM_PE]) begin
                        s_next.ccr_act[1] = reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end

        // counter, up only
        if (ug || rst_trig) begin
            s_next.cnt = `TCP_ZERO16;
        end else if (ovf) begin
            s_next.cnt = `TCP_ZERO16;
        end else if (adv && !cnt_wr) begin
            s_next.cnt = 16'(s_reg.cnt + `TCP_ONE16);
        end
        s_next.cnt_new = adv || ug || rst_trig;

        // run bit
        if ((s_reg.slave_mode_field == `TCP_SMS_TRIGGER) && edge_det) begin
            s_next.run = 1'h1;
        end
        if (ovf && s_reg.sp) begin
            s_next.run = 1'h0;
        end

        // update event loads working copies
        if (upd) begin
            if (s_reg.autoreload_preload_enable) s_next.arr_act = s_reg.arr_pre;
            for (int i = 0; i < 2; i++) begin
                if (s_reg.chmode[i * `TCP_CHM_STRIDE + `TCP_CHM_PE]) begin
                    s_next.ccr_act[i] = s_reg.ccr_pre[i];
                end
            end
        end

        // flags, set wins over clear
        s_next.cc_f = s_next.cc_f | match;
        if (ovf || ((ug || rst_trig) && !s_reg.update_source_select)) s_next.upd_f = 1'h1;
        if (rst_trig || ((s_reg.slave_mode_field == `TCP_SMS_TRIGGER) && edge_det)) begin
            s_next.trg_f = 1'h1;
        end
        if ((s_reg.slave_mode_field == `TCP_SMS_GATED) && s_reg.run && (lvl != s_reg.trg_prev)) begin
            s_next.trg_f = 1'h1;
        end
        s_next.irq = |(s_next.cc_f & s_next.cc_ie) || (s_next.trg_f && s_next.trg_ie);

        // pins
        for (int i = 0; i < 2; i++) begin
            if (s_reg.chout[i * `TCP_CHO_STRIDE + `TCP_CHO_EN]) begin
                s_next.out_lvl[i] = ref_lvl[i] ^ s_reg.chout[i * `TCP_CHO_STRIDE + `TCP_CHO_POL];
                s_next.out_oe_b[i] = 1'h0;
            end else begin
                s_next.out_lvl[i] = 1'h0;
                s_next.out_oe_b[i] = 1'h1;
            end
        end

        // read answer, one cycle late, zero elsewhere
        s_next.rdata = `TCP_ZERO16;
        if (reg_rd) begin
            unique case (reg_addr)
                `TCP_OFS_CTRL: begin
                    s_next.rdata[`TCP_CTRL_RUN] = s_reg.run;
                    s_next.rdata[`TCP_CTRL_URS] = s_reg.update_source_select;
                    s_next.rdata[`TCP_CTRL_SP] = s_reg.sp;
                    s_next.rdata[`TCP_CTRL_AUTORELOAD_PRELOAD_ENABLE] = s_reg.autoreload_preload_enable;
                end
                `TCP_OFS_SLAVE: begin
                    s_next.rdata[`TCP_SLV_SMS +: 3] = s_reg.slave_mode_field;
                    s_next.rdata[`TCP_SLV_TS +: 3] = s_reg.ts;
                end
                `TCP_OFS_IRQEN: begin
                    s_next.rdata[`TCP_FLG_CC +: 2] = s_reg.cc_ie;
                    s_next.rdata[`TCP_FLG_TRG] = s_reg.trg_ie;
                end
                `TCP_OFS_STATUS: begin
                    s_next.rdata[`TCP_FLG_UPD] = s_reg.upd_f;
                    s_next.rdata[`TCP_FLG_CC +: 2] = s_reg.cc_f;
                    s_next.rdata[`TCP_FLG_TRG] = s_reg.trg_f;
                end
                `TCP_OFS_CHMODE: s_next.rdata = s_reg.chmode;
                `TCP_OFS_CHOUT: s_next.rdata[7:0] = s_reg.chout;
                `TCP_OFS_CNT: s_next.rdata = s_reg.cnt;
                `TCP_OFS_ARR: s_next.rdata = s_reg.arr_pre;
                `TCP_OFS_CCR1: s_next.rdata = s_reg.ccr_pre[0];
                `TCP_OFS_CCR2: s_next.rdata = s_reg.ccr_pre[1];
                default: s_next.rdata = `TCP_ZERO16;
            endcase
        end
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.arr_pre <= `TCP_ARR_RST;
            s_reg.arr_act <= `TCP_ARR_RST;
            s_reg.out_oe_b <= `TCP_OE_OFF;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rdata;
    assign chan_out = s_reg.out_lvl;
    assign chan_oe_b = s_reg.out_oe_b;
    assign irq_req = s_reg.irq;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_match_flag_set: assert property (@(posedge mclk) disable iff (!rst_b)
        match[0] |=> s_reg.cc_f[0])
        else $error("match flag not set");
    a_irq_gating: assert property (@(posedge mclk) disable iff (!rst_b)
        irq_req == (|(s_reg.cc_f & s_reg.cc_ie) || (s_reg.trg_f && s_reg.trg_ie)))
        else $error("interrupt request not gated by enables");
    a_preload_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        s_reg.chmode[`TCP_CHM_PE] && !upd |=> $stable(s_reg.ccr_act[0]))
        else $error("working compare changed without update");
    a_single_stop: assert property (@(posedge mclk) disable iff (!rst_b)
        ovf && s_reg.sp |=> !s_reg.run && s_reg.cnt == `TCP_ZERO16)
        else $error("single pulse did not stop");
    a_reset_restart: assert property (@(posedge mclk) disable iff (!rst_b)
        rst_trig |=> s_reg.cnt == `TCP_ZERO16 && s_reg.trg_f)
        else $error("reset trigger did not restart");
    a_gated_pause: assert property (@(posedge mclk) disable iff (!rst_b)
        s_reg.slave_mode_field == `TCP_SMS_GATED && !lvl && !ug && !cnt_wr |=> $stable(s_reg.cnt))
        else $error("gated counter moved");
    a_trig_start: assert property (@(posedge mclk) disable iff (!rst_b)
        s_reg.slave_mode_field == `TCP_SMS_TRIGGER && edge_det && !(ovf && s_reg.sp) |=> s_reg.run)
        else $error("trigger edge did not start counter");
    a_out_disable: assert property (@(posedge mclk) disable iff (!rst_b)
        !s_reg.chout[`TCP_CHO_EN] |=> chan_oe_b[0] && !chan_out[0])
        else $error("disabled output driven");
    a_sync_delay: assert property (@(posedge mclk) disable iff (!rst_b)
        s_reg.ts == `TCP_TS_IN1 && !inv[0] && $stable(s_reg.ts) && $stable(inv[0])
        |-> lvl == $past(trig_in[0], 2))
        else $error("trigger not two stages late");
endmodule // tcp_top

// ==== bench/tcp_pins_model.sv ====
// far-side model: trigger pin drivers and waveform pin monitor
`timescale 1ns/100ps
module tcp_pins_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // commands from the bench
    input wire logic [1:0] lvl_cmd,
    input wire logic meas,
    // waveform pins
    input wire logic [1:0] chan_out,
    // trigger pins and high-cycle count
    output logic [1:0] trig_in,
    output logic [15:0] hi_cnt
);
    logic meas_q;

    // ---------------------------------------------
    // trigger pins, each level held whole cycles
    // ---------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trig_in <= 2'b00;
        end else begin
            trig_in <= lvl_cmd;
        end
    end

    // ---------------------------------------------
    // high cycles of channel one while measuring
    // ---------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meas_q <= 1'b0;
            hi_cnt <= 16'h0000;
        end else begin
            meas_q <= meas;
            if (meas) begin
                hi_cnt <= (meas_q ? hi_cnt : 16'h0000) + {15'h0000, chan_out[0]};
            end
        end
    end
endmodule // tcp_pins_model

// ==== bench/test_timer_compare_pwm_slave_ctrl.sv ====
// self-checking bench of the timer compare, pwm and slave block
`timescale 1ns/100ps
`include "tcp_consts.svh"
module test_timer_compare_pwm_slave_ctrl;
    // ---------------------------------------------
    // signals
    // ---------------------------------------------
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, hi_cnt, d, d0, a, c;
    logic [1:0] trig_in, chan_out, chan_oe_b;
    logic irq_req, en;
    logic [1:0] lvl = 2'b00;
    logic meas = 1'b0;
    logic [31:0] r = 32'ha2e7_f571;
    int miscompares = 0;
    int cmp_count = 0;

    tcp_top u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
        .chan_out(chan_out), .chan_oe_b(chan_oe_b), .irq_req(irq_req));
    tcp_pins_model u_pins (.mclk(mclk), .rst_b(rst_b), .lvl_cmd(lvl), .meas(meas),
        .chan_out(chan_out), .trig_in(trig_in), .hi_cnt(hi_cnt));

    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // high cycles in three periods
    function automatic logic [15:0] exp_pwm(input logic [15:0] ar, cr, input logic m2, pl, e);
        logic [15:0] h;
        h = (cr > ar) ? ar + 16'h0001 : cr;
        if (m2 ^ pl) begin
            h = ar + 16'h0001 - h;
        end
        return e ? 16'(3 * h) : 16'h0000;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [15:0] v);
        @(posedge mclk);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [15:0] v);
        @(posedge mclk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic chk(input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        forever #25 mclk = ~mclk;
    end

    initial begin
        tick(40000);
        miscompares++;
        results();
    end

    // ---------------------------------------------
    // sequence
    // ---------------------------------------------
    initial begin
        tick(8);
        rst_b <= 1'b1;
        chk({14'h0000, chan_oe_b}, 16'h0003);
        wr(8'h04, 16'hffff);
        rd(8'h04, d);
        chk(d, 16'h0000);
        // compare actions, preset by forced levels
        for (int m = 0; m < 4; m++) begin
            wr(`TCP_OFS_CTRL, 16'h0000);
            wr(`TCP_OFS_CHOUT, 16'h0001);
            wr(`TCP_OFS_CNT, 16'h0000);
            wr(`TCP_OFS_CCR1, 16'h0008);
            wr(`TCP_OFS_STATUS, 16'h0000);
            wr(`TCP_OFS_IRQEN, m[0] ? 16'h0002 : 16'h0000);
            wr(`TCP_OFS_CHMODE, (m == 1 || m == 3) ? 16'h0040 : 16'h0050);
            wr(`TCP_OFS_CHMODE, 16'(m << 4));
            wr(`TCP_OFS_CTRL, 16'h0001);
            tick(20);
            wr(`TCP_OFS_CTRL, 16'h0000);
            tick(3);
            chk(16'(chan_out[0]), (m == 2) ? 16'h0000 : 16'h0001);
            chk(16'(irq_req), 16'(m[0]));
            rd(`TCP_OFS_STATUS, d);
            chk(16'(d[1]), 16'h0001);
            wr(`TCP_OFS_EVGEN, 16'h0001);
            tick(3);
            chk(16'(chan_out[0]), (m == 2) ? 16'h0000 : 16'h0001);
        end
        // random pwm, first two at duty extremes
        for (int i = 0; i < 12; i++) begin
            r = lfsr(r);
            a = 16'h0004 + 16'(r[3:0]);
            c = (i == 0) ? 16'h0000 : (i == 1) ? a + 16'h0001 : 16'(r[8:4]) % (a + 16'h0003);
            en = r[11] | r[12];
            wr(`TCP_OFS_CTRL, 16'h0000);
            wr(`TCP_OFS_ARR, a);
            wr(`TCP_OFS_CCR1, c);
            wr(`TCP_OFS_CHMODE, {9'h000, 2'b11, r[9], 4'h8});
            wr(`TCP_OFS_CHOUT, {14'h0000, r[10], en});
            wr(`TCP_OFS_EVGEN, 16'h0001);
            wr(`TCP_OFS_CTRL, 16'h0081);
            tick(30);
            meas <= 1'b1;
            tick(3 * (a + 1));
            meas <= 1'b0;
            #1;
            chk(hi_cnt, exp_pwm(a, c, r[9], r[10], en));
            chk({15'h0000, chan_oe_b[0]}, {15'h0000, ~en});
        end
        // single pulse from input two, delay 10, reload 40, then with fast path
        for (int f = 0; f < 2; f++) begin
            wr(`TCP_OFS_CTRL, 16'h0000);
            wr(`TCP_OFS_CHMODE, f ? 16'h007c : 16'h0078);
            wr(`TCP_OFS_CHOUT, 16'h0001);
            wr(`TCP_OFS_ARR, 16'h0028);
            wr(`TCP_OFS_CCR1, 16'h000a);
            wr(`TCP_OFS_EVGEN, 16'h0001);
            wr(`TCP_OFS_SLAVE, 16'h0066);
            wr(`TCP_OFS_CTRL, 16'h0008);
            meas <= 1'b1;
            lvl <= 2'b10;
            tick(8);
            rd(`TCP_OFS_CTRL, d);
            chk(16'(d[0]), 16'h0001);
            tick(60);
            meas <= 1'b0;
            lvl <= 2'b00;
            #1;
            // fast path drops the delay: pulse spans reload plus one
            chk(hi_cnt, f ? 16'h0029 : 16'h001f);
            rd(`TCP_OFS_CTRL, d);
            chk(16'(d[0]), 16'h0000);
            rd(`TCP_OFS_CNT, d);
            chk(d, 16'h0000);
        end
        // reset mode on input one, input two ignored
        wr(`TCP_OFS_CTRL, 16'h0000);
        wr(`TCP_OFS_ARR, 16'hffff);
        wr(`TCP_OFS_SLAVE, 16'h0054);
        wr(`TCP_OFS_IRQEN, 16'h0040);
        wr(`TCP_OFS_STATUS, 16'h0000);
        wr(`TCP_OFS_CTRL, 16'h0001);
        tick(30);
        lvl <= 2'b10;
        tick(6);
        rd(`TCP_OFS_STATUS, d);
        chk(16'(d[6]), 16'h0000);
        lvl <= 2'b11;
        tick(5);
        rd(`TCP_OFS_CNT, d);
        chk(16'(d < 16'h0008), 16'h0001);
        rd(`TCP_OFS_STATUS, d);
        chk(16'(d[6]), 16'h0001);
        chk(16'(irq_req), 16'h0001);
        // gated mode, input one active low
        lvl <= 2'b01;
        wr(`TCP_OFS_CTRL, 16'h0000);
        wr(`TCP_OFS_CHOUT, 16'h0002);
        wr(`TCP_OFS_SLAVE, 16'h0055);
        wr(`TCP_OFS_CNT, 16'h0000);
        wr(`TCP_OFS_CTRL, 16'h0001);
        tick(6);
        wr(`TCP_OFS_STATUS, 16'h0000);
        rd(`TCP_OFS_CNT, d);
        chk(d, 16'h0000);
        lvl <= 2'b00;
        tick(10);
        rd(`TCP_OFS_STATUS, d);
        chk(16'(d[6]), 16'h0001);
        wr(`TCP_OFS_STATUS, 16'h0000);
        lvl <= 2'b01;
        tick(6);
        rd(`TCP_OFS_STATUS, d);
        chk(16'(d[6]), 16'h0001);
        rd(`TCP_OFS_CNT, d0);
        tick(5);
        rd(`TCP_OFS_CNT, d);
        chk(d, d0);
        chk(16'(d0 > 16'h0004), 16'h0001);
        results();
    end
endmodule // test_timer_compare_pwm_slave_ctrl
